// [ppc_config_regs.sv]
// Purpose: Parallel-port configuration register bank behind an APB slave.
// Assumes: Host I/O reads arrive as a synchronous strobe with a 16-bit address.
// Notes: Zero-wait APB; unmapped aligned words and misaligned addresses raise pslverr.
`timescale 1ns/1ps
module ppc_config_regs #(
  parameter int ADDR_W = 12,
  parameter logic [15:0] PORT_SPAN = 16'h0008
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host I/O read probe
  input wire logic ioRead,
  input wire logic [15:0] ioAddr,
  output logic ioRespValid,
  output logic [7:0] ioRespData,
  // Configuration to the port logic
  output logic portEnable,
  output logic checkActive,
  output logic eppEnable,
  output logic ecpEnable,
  output logic irqShared,
  output logic [15:0] primaryBase,
  output logic [15:0] secondaryBase,
  output logic secondaryValid,
  output logic [3:0] irqLevel,
  output logic irqLevelValid,
  output logic [2:0] dmaChannel,
  output logic dmaValid
);
  import ppc_pkg::*;

  // Reset release through two flops
  logic rstMeta_q;
  logic rstN_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstN_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN_q <= rstMeta_q;
    end
  end

  // Interrupt level is legal when none or within the 3h..Bh window
  function automatic logic irq_ok(input logic [3:0] lvl);
    irq_ok = (lvl == IRQ_NONE) || ((lvl >= IRQ_LOW_OK) && (lvl <= IRQ_HIGH_OK));
  endfunction : irq_ok

  // Masked merge keeps fixed bits at their stored constant
  function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] wd,
                                        input logic [7:0] mask);
    wmerge = (old & ~mask) | (wd & mask);
  endfunction : wmerge

  // Register storage
  logic [7:0] ldn_q;
  logic [7:0] cfgMode_q;
  logic [7:0] act_q;
  logic [7:0] rchk_q;
  logic [7:0] pbHi_q;
  logic [7:0] pbLo_q;
  logic [7:0] sbHi_q;
  logic [7:0] sbLo_q;
  logic [7:0] irqLvl_q;
  logic [7:0] dma_q;
  logic [7:0] spc_q;
  logic ioRespValid_q;
  logic [7:0] ioRespData_q;

  // Address decode
  wire logic [7:0] idx = paddr[9:2];
  wire logic aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
  wire logic ldnSel = (ldn_q == LDN_PARALLEL);
  wire logic isGlobal = (idx == IDX_LDN) || (idx == IDX_CFG_MODE);
  wire logic isBank = (idx == IDX_ACT) || (idx == IDX_RCHK) || (idx == IDX_STATUS)
                   || (idx == IDX_PBASE_HI) || (idx == IDX_PBASE_LO)
                   || (idx == IDX_SBASE_HI) || (idx == IDX_SBASE_LO)
                   || (idx == IDX_IRQ_LVL) || (idx == IDX_IRQ_TYPE)
                   || (idx == IDX_DMA) || (idx == IDX_SPECIAL);
  wire logic mapped = aligned && (isGlobal || isBank);
  wire logic access = psel && penable;
  wire logic wrEn = access && pwrite && mapped;
  wire logic bankWr = wrEn && isBank && ldnSel;
  wire logic [7:0] wd = pwdata[7:0];

  // Derived configuration
  wire logic mbMode = cfgMode_q[MODE_MB_BIT];
  wire logic eppBlock = pbLo_q[PLO_EPP_BLOCK_BIT];
  wire logic checkOn = rchk_q[RCHK_EN_BIT] && !act_q[ACT_EN_BIT] && !mbMode;
  wire logic [15:0] pBase = {4'h0, pbHi_q[3:0], pbLo_q[7:2], 2'b00};
  wire logic [15:0] sBase = {4'h0, sbHi_q[3:0], sbLo_q[7:2], 2'b00};
  wire logic inPrimary = (ioAddr >= pBase) && (ioAddr < pBase + PORT_SPAN);
  wire logic inSecondary = spc_q[SPC_ECP_BIT] && (ioAddr >= sBase)
                        && (ioAddr < sBase + PORT_SPAN);
  wire logic ioHit = ioRead && checkOn && (inPrimary || inSecondary);
  wire logic [7:0] pattern = rchk_q[RCHK_PAT_BIT] ? PAT_SET : PAT_CLR;
  wire logic [7:0] statusVal = {3'b000, !(dma_q[2:0] <= DMA_NONE),
                                !irq_ok(irqLvl_q[3:0]), checkOn, eppEnable, ecpEnable};

  // Read mux; the bank reads as zero when another device is selected
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    if (aligned && idx == IDX_LDN) rdByte = ldn_q;
    else if (aligned && idx == IDX_CFG_MODE) rdByte = cfgMode_q;
    else if (aligned && ldnSel) begin
      case (idx)
        IDX_ACT: rdByte = act_q;
        IDX_RCHK: rdByte = rchk_q;
        IDX_STATUS: rdByte = statusVal;
        IDX_PBASE_HI: rdByte = pbHi_q;
        IDX_PBASE_LO: rdByte = pbLo_q;
        IDX_SBASE_HI: rdByte = sbHi_q;
        IDX_SBASE_LO: rdByte = sbLo_q;
        IDX_IRQ_LVL: rdByte = irqLvl_q;
        IDX_IRQ_TYPE: rdByte = VAL_IRQ_TYPE;
        IDX_DMA: rdByte = dma_q;
        IDX_SPECIAL: rdByte = spc_q;
        default: rdByte = 8'h00;
      endcase
    end
  end

  // APB answer: zero wait, error on unmapped words
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = (access && !pwrite) ? {24'h000000, rdByte} : 32'h00000000;

  // Selector registers outside the bank
  always_ff @(posedge clk or negedge rstN_q) begin
    if (!rstN_q) begin
      ldn_q <= RST_LDN;
      cfgMode_q <= RST_CFG_MODE;
    end else if (wrEn && idx == IDX_LDN) begin
      ldn_q <= wd;
    end else if (wrEn && idx == IDX_CFG_MODE) begin
      cfgMode_q <= wmerge(cfgMode_q, wd, WM_CFG_MODE);
    end
  end

  // Bank registers; masks keep fixed bits constant
  always_ff @(posedge clk or negedge rstN_q) begin
    if (!rstN_q) begin
      act_q <= RST_ACT;
      rchk_q <= RST_RCHK;
      pbHi_q <= RST_PBASE_HI;
      pbLo_q <= RST_PBASE_LO;
      sbHi_q <= RST_SBASE_HI;
      sbLo_q <= RST_SBASE_LO;
      irqLvl_q <= RST_IRQ_LVL;
      dma_q <= RST_DMA;
      spc_q <= RST_SPECIAL;
    end else if (bankWr) begin
      case (idx)
        IDX_ACT: act_q <= wmerge(act_q, wd, WM_ACT);
        IDX_RCHK: rchk_q <= wmerge(rchk_q, wd, WM_RCHK);
        IDX_PBASE_HI: pbHi_q <= wmerge(pbHi_q, wd, WM_BASE_HI);
        IDX_PBASE_LO: pbLo_q <= wmerge(pbLo_q, wd, WM_BASE_LO);
        IDX_SBASE_HI: sbHi_q <= wmerge(sbHi_q, wd, WM_BASE_HI);
        IDX_SBASE_LO: sbLo_q <= wmerge(sbLo_q, wd, WM_BASE_LO);
        IDX_IRQ_LVL: irqLvl_q <= wmerge(irqLvl_q, wd, WM_IRQ_LVL);
        IDX_DMA: dma_q <= wmerge(dma_q, wd, WM_DMA);
        IDX_SPECIAL: spc_q <= wmerge(spc_q, wd, WM_SPECIAL);
        default: act_q <= act_q;
      endcase
    end
  end

  // Range-check answer, registered one cycle after the strobe
  always_ff @(posedge clk or negedge rstN_q) begin
    if (!rstN_q) begin
      ioRespValid_q <= 1'b0;
      ioRespData_q <= 8'h00;
    end else begin
      ioRespValid_q <= ioHit;
      ioRespData_q <= ioHit ? pattern : 8'h00;
    end
  end

  // Outputs to the port logic
  assign ioRespValid = ioRespValid_q;
  assign ioRespData = ioRespData_q;
  assign portEnable = act_q[ACT_EN_BIT];
  assign checkActive = checkOn;
  assign eppEnable = spc_q[SPC_EPP_BIT] && !eppBlock;
  assign ecpEnable = spc_q[SPC_ECP_BIT];
  assign irqShared = spc_q[SPC_SHARE_BIT];
  assign primaryBase = pBase;
  assign secondaryBase = sBase;
  assign secondaryValid = spc_q[SPC_ECP_BIT];
  // Invalid levels are reported but not driven to a line
  assign irqLevelValid = irq_ok(irqLvl_q[3:0]);
  assign irqLevel = irq_ok(irqLvl_q[3:0]) ? irqLvl_q[3:0] : IRQ_NONE;
  assign dmaValid = (dma_q[2:0] < DMA_NONE);
  assign dmaChannel = (dma_q[2:0] < DMA_NONE) ? dma_q[2:0] : DMA_NONE;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN_q);

  sequence s_bank_wr(logic [7:0] i);
    access && pwrite && aligned && idx == i;
  endsequence

  sequence s_bank_rd(logic [7:0] i);
    access && !pwrite && aligned && idx == i && ldnSel;
  endsequence

  chk_ldn_gates_write: assert property (
    s_bank_wr(IDX_SPECIAL) and (!ldnSel) |=> $stable(irqShared) && $stable(ecpEnable))
    else $error("bank write took effect under another device number");

  chk_act_enable: assert property (
    s_bank_wr(IDX_ACT) and (ldnSel) |=> portEnable == $past(pwdata[0]))
    else $error("activate bit did not follow the write");

  chk_check_inactive: assert property (
    checkActive |-> !portEnable && !$past(bankWr && idx == IDX_ACT && pwdata[0]))
    else $error("range check running while port active");

  chk_range_pattern: assert property (
    ioHit |=> ioRespValid && ioRespData == ($past(rchk_q[0]) ? 8'h55 : 8'hAA))
    else $error("range check answer wrong");

  chk_mb_no_check: assert property (
    ioRead && mbMode |=> !ioRespValid)
    else $error("range check answered in motherboard mode");

  chk_phi_readback: assert property (
    s_bank_rd(IDX_PBASE_HI) |-> prdata[7:4] == 4'h0 && prdata[3:0] == primaryBase[11:8])
    else $error("primary high readback wrong");

  chk_plo_lowbits: assert property (
    s_bank_rd(IDX_PBASE_LO) |-> prdata[1:0] == 2'b00 && prdata[7:2] == primaryBase[7:2])
    else $error("primary low readback wrong");

  chk_sec_ecp_only: assert property (
    secondaryValid == ecpEnable && secondaryBase[15:12] == 4'h0)
    else $error("secondary base use not tied to ECP");

  chk_irq_invalid: assert property (
    s_bank_wr(IDX_IRQ_LVL) and (ldnSel && pwdata[3:0] >= 4'hC) |=> !irqLevelValid ##0
    irqLevel == 4'h0)
    else $error("invalid interrupt level accepted");

  chk_type_fixed: assert property (
    s_bank_rd(IDX_IRQ_TYPE) |-> prdata == 32'h00000002)
    else $error("interrupt type not 02h");

  chk_dma_decode: assert property (
    s_bank_wr(IDX_DMA) and (ldnSel) |=> dmaValid == ($past(pwdata[2:0]) < 3'h4))
    else $error("DMA channel decode wrong");

  chk_share_bit: assert property (
    s_bank_wr(IDX_SPECIAL) and (ldnSel) |=> irqShared == $past(pwdata[2]))
    else $error("sharing bit did not follow the write");

  chk_ecp_mode: assert property (
    s_bank_wr(IDX_SPECIAL) and (ldnSel) |=> ecpEnable == $past(pwdata[1]))
    else $error("ECP enable did not follow mode bit");

  chk_epp_block: assert property (
    primaryBase[2] |-> !eppEnable)
    else $error("EPP enabled with base bit 2 set");

  chk_ro_ignored: assert property (
    s_bank_wr(IDX_PBASE_HI) and (ldnSel) |=> primaryBase[15:12] == 4'h0 ##1
    primaryBase[15:12] == 4'h0)
    else $error("read-only base bits changed");

  // Bank visibility, fixed bits and the probe answer path
  chk_hidden_read: assert property (
    access && !pwrite && aligned && isBank && !ldnSel |-> prdata == 32'h00000000)
    else $error("bank read visible under another device number");

  chk_hidden_write: assert property (
    s_bank_wr(IDX_ACT) and (!ldnSel) |=> $stable(portEnable))
    else $error("activate write took effect under another device number");

  chk_act_fixed_bits: assert property (
    s_bank_rd(IDX_ACT) |-> prdata[7:1] == 7'h00)
    else $error("activate reserved bits not zero");

  chk_active_no_check: assert property (
    portEnable |-> !checkActive)
    else $error("range check running on an active port");

  chk_rchk_fixed_bits: assert property (
    s_bank_rd(IDX_RCHK) |-> prdata[7:2] == 6'h00)
    else $error("range check reserved bits not zero");

  chk_answer_follows: assert property (
    ioRespValid |-> $past(ioHit))
    else $error("range check answer without a hit");

  chk_answer_pattern: assert property (
    ioRespValid |-> ioRespData == PAT_SET || ioRespData == PAT_CLR)
    else $error("range check answer not a pattern");

  chk_answer_idle: assert property (
    !ioRespValid |-> ioRespData == 8'h00)
    else $error("range check data without valid");

  chk_mb_check_off: assert property (
    mbMode |-> !checkActive)
    else $error("range check running in motherboard mode");

  chk_phi_write: assert property (
    s_bank_wr(IDX_PBASE_HI) and (ldnSel) |=> primaryBase[11:8] == $past(pwdata[3:0]))
    else $error("primary high bits did not follow the write");

  chk_plo_write: assert property (
    s_bank_wr(IDX_PBASE_LO) and (ldnSel) |=> primaryBase[7:0] == {$past(pwdata[7:2]), 2'b00})
    else $error("primary low bits did not follow the write");

  chk_slo_write: assert property (
    s_bank_wr(IDX_SBASE_LO) and (ldnSel) |=> secondaryBase[7:2] == $past(pwdata[7:2]))
    else $error("secondary low bits did not follow the write");

  chk_sec_ecp_gate: assert property (
    ioRead && checkOn && !ecpEnable && !inPrimary |=> !ioRespValid)
    else $error("secondary range answered with ECP off");

  chk_irq_low_invalid: assert property (
    s_bank_wr(IDX_IRQ_LVL) and (ldnSel && pwdata[3:0] inside {4'h1, 4'h2})
    |=> !irqLevelValid)
    else $error("interrupt level 1h or 2h accepted");

  chk_irq_fixed_bits: assert property (
    s_bank_rd(IDX_IRQ_LVL) |-> prdata[7:4] == 4'h0)
    else $error("interrupt level reserved bits not zero");

  chk_dma_none_out: assert property (
    !dmaValid |-> dmaChannel == DMA_NONE)
    else $error("invalid DMA value reached the channel output");

  chk_dma_fixed_bits: assert property (
    s_bank_rd(IDX_DMA) |-> prdata[7:3] == 5'h00)
    else $error("DMA reserved bits not zero");

  chk_spc_fixed_bits: assert property (
    s_bank_rd(IDX_SPECIAL) |-> prdata[7:3] == 5'h00)
    else $error("special configuration reserved bits not zero");

  chk_epp_follow: assert property (
    s_bank_wr(IDX_SPECIAL) and (ldnSel && !primaryBase[2]) |=> eppEnable == $past(pwdata[0]))
    else $error("EPP enable did not follow mode bit");

endmodule : ppc_config_regs

// [ppc_pkg.sv]
// Purpose: Constants for the parallel-port configuration register bank.
// Assumes: Registers sit on APB, one aligned 32-bit word each, byte address = index * 4.
// Notes: Only the low byte of each word carries data; upper bits read as zero.
package ppc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_CFG_MODE = 8'h08;
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_RCHK = 8'h31;
  localparam logic [7:0] IDX_STATUS = 8'h38;
  localparam logic [7:0] IDX_PBASE_HI = 8'h60;
  localparam logic [7:0] IDX_PBASE_LO = 8'h61;
  localparam logic [7:0] IDX_SBASE_HI = 8'h62;
  localparam logic [7:0] IDX_SBASE_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ_LVL = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_DMA = 8'h74;
  localparam logic [7:0] IDX_SPECIAL = 8'hF0;

  // Logical device number owning this bank
  localparam logic [7:0] LDN_PARALLEL = 8'h03;

  // Reset values
  localparam logic [7:0] RST_LDN = 8'h00;
  localparam logic [7:0] RST_CFG_MODE = 8'h00;
  localparam logic [7:0] RST_ACT = 8'h00;
  localparam logic [7:0] RST_RCHK = 8'h00;
  localparam logic [7:0] RST_PBASE_HI = 8'h03;
  localparam logic [7:0] RST_PBASE_LO = 8'h78;
  localparam logic [7:0] RST_SBASE_HI = 8'h07;
  localparam logic [7:0] RST_SBASE_LO = 8'h78;
  localparam logic [7:0] RST_IRQ_LVL = 8'h07;
  localparam logic [7:0] VAL_IRQ_TYPE = 8'h02;
  localparam logic [7:0] RST_DMA = 8'h03;
  localparam logic [7:0] RST_SPECIAL = 8'h03;

  // Writable bit masks; all other bits are fixed
  localparam logic [7:0] WM_CFG_MODE = 8'h01;
  localparam logic [7:0] WM_ACT = 8'h01;
  localparam logic [7:0] WM_RCHK = 8'h03;
  localparam logic [7:0] WM_BASE_HI = 8'h0F;
  localparam logic [7:0] WM_BASE_LO = 8'hFC;
  localparam logic [7:0] WM_IRQ_LVL = 8'h0F;
  localparam logic [7:0] WM_DMA = 8'h07;
  localparam logic [7:0] WM_SPECIAL = 8'h07;

  // Field positions
  localparam int ACT_EN_BIT = 0;
  localparam int RCHK_PAT_BIT = 0;
  localparam int RCHK_EN_BIT = 1;
  localparam int SPC_EPP_BIT = 0;
  localparam int SPC_ECP_BIT = 1;
  localparam int SPC_SHARE_BIT = 2;
  localparam int PLO_EPP_BLOCK_BIT = 2;
  localparam int MODE_MB_BIT = 0;

  // Range-check answer patterns
  localparam logic [7:0] PAT_SET = 8'h55;
  localparam logic [7:0] PAT_CLR = 8'hAA;

  // Interrupt and DMA encodings
  localparam logic [3:0] IRQ_NONE = 4'h0;
  localparam logic [3:0] IRQ_LOW_OK = 4'h3;
  localparam logic [3:0] IRQ_HIGH_OK = 4'hB;
  localparam logic [2:0] DMA_NONE = 3'h4;

endpackage : ppc_pkg

// [ppc_host_io.sv]
// Purpose: Host model issuing I/O reads toward the range-check probe.
// Assumes: One read strobe per requested cycle, launched after a rising edge.
// Notes: Idle address lines show the inverse of the last value, so every second idle cycle repeats the old address.
`timescale 1ns/1ps
module ppc_host_io (
  // Clock
  input wire logic clk,
  // Request from the bench
  input wire logic req,
  input wire logic [15:0] reqAddr,
  // Host I/O read lines
  output logic ioRead,
  output logic [15:0] ioAddr
);
  initial begin
    ioRead = 1'b0;
    ioAddr = 16'hFFFF;
  end
  // Released bus drifts so a held address can never fake a hit
  always @(posedge clk) begin
    ioRead <= req;
    ioAddr <= req ? reqAddr : ~ioAddr;
  end
endmodule : ppc_host_io

// [tb_top.sv]
// Purpose: Self-checking bench for the parallel-port configuration bank.
// Assumes: Zero-wait APB slave; byte address is four times the register index.
// Notes: Drivers queue expected reads and probe answers; a monitor checks them.
`timescale 1ns/1ps
module tb_top;
  import ppc_pkg::*;
  logic clk, nrst, psel, penable, pwrite, ioReq, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [15:0] reqAddr;
  logic [7:0] r;
  logic [7:0] wd [10];
  wire [31:0] prdata;
  wire pready, pslverr, ioRead, ioRespValid, portEnable, checkActive, eppEnable;
  wire ecpEnable, irqShared, secondaryValid, irqLevelValid, dmaValid;
  wire [15:0] ioAddr, primaryBase, secondaryBase;
  wire [7:0] ioRespData;
  wire [3:0] irqLevel;
  wire [2:0] dmaChannel;
  int bad_count = 0;
  int check_count = 0;
  int seed = 95;
  logic [32:0] rdq [$];
  logic [7:0] ioq [$];
  localparam logic [7:0] IDX_T [10] = '{IDX_ACT, IDX_RCHK, IDX_PBASE_HI, IDX_PBASE_LO,
    IDX_SBASE_HI, IDX_SBASE_LO, IDX_IRQ_LVL, IDX_IRQ_TYPE, IDX_DMA, IDX_SPECIAL};
  localparam logic [7:0] RST_T [10] = '{RST_ACT, RST_RCHK, RST_PBASE_HI, RST_PBASE_LO,
    RST_SBASE_HI, RST_SBASE_LO, RST_IRQ_LVL, VAL_IRQ_TYPE, RST_DMA, RST_SPECIAL};
  localparam logic [7:0] MSK_T [10] = '{WM_ACT, WM_RCHK, WM_BASE_HI, WM_BASE_LO,
    WM_BASE_HI, WM_BASE_LO, WM_IRQ_LVL, 8'h00, WM_DMA, WM_SPECIAL};

  ppc_config_regs #(.ADDR_W(12), .PORT_SPAN(16'h0008)) u_ppc_config_regs (.clk(clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ioRead(ioRead),
    .ioAddr(ioAddr), .ioRespValid(ioRespValid), .ioRespData(ioRespData),
    .portEnable(portEnable), .checkActive(checkActive), .eppEnable(eppEnable),
    .ecpEnable(ecpEnable), .irqShared(irqShared), .primaryBase(primaryBase),
    .secondaryBase(secondaryBase), .secondaryValid(secondaryValid), .irqLevel(irqLevel),
    .irqLevelValid(irqLevelValid), .dmaChannel(dmaChannel), .dmaValid(dmaValid));
  ppc_host_io u_ppc_host_io (.clk(clk), .req(ioReq), .reqAddr(reqAddr), .ioRead(ioRead),
    .ioAddr(ioAddr));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic cmp_val(input string nm, input logic [32:0] exp, input logic [32:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp_val

  task automatic complete_run();
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] idx, input logic [32:0] exp);
    rdq.push_back(exp);
    apb(idx, 1'b0, 8'h00);
  endtask : rd

  // Host I/O read; an answer is queued only where a hit is due
  task automatic probe(input logic [15:0] a, input logic hit, input logic [7:0] d);
    if (hit)
      ioq.push_back(d);
    @(posedge clk);
    ioReq <= 1'b1;
    reqAddr <= a;
    @(posedge clk);
    ioReq <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : probe

  // Monitor: every completed read and every probe answer takes the oldest note
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (rdq.size() == 0)
        cmp_val("unexpected read", 33'h0, 33'h1);
      else
        cmp_val("prdata", rdq.pop_front(), {pslverr, prdata});
    end
    if (ioRespValid === 1'b1) begin
      if (ioq.size() == 0)
        cmp_val("unexpected probe answer", 33'h0, 33'h1);
      else
        cmp_val("ioRespData", {25'h0, ioq.pop_front()}, {25'h0, ioRespData});
    end
  end

  // Watchdog sized well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, ioReq, nrst} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    reqAddr = 16'h0000;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // Bank stays hidden until the parallel device number is selected
    apb(IDX_ACT, 1'b1, 8'h01);
    rd(IDX_ACT, 33'h0);
    cmp_val("portEnable", 33'h0, 33'(portEnable));
    apb(IDX_SPECIAL, 1'b1, 8'h04);
    cmp_val("irqShared", 33'h0, 33'(irqShared));
    apb(IDX_LDN, 1'b1, LDN_PARALLEL);
    for (int i = 0; i < 10; i++) begin
      rd(IDX_T[i], {25'h0, RST_T[i]});
    end
    rd(8'h40, {1'b1, 32'h0});
    // Random fill; check bit kept clear so checking never meets an active port
    for (int i = 0; i < 10; i++) begin
      r = 8'($random(seed));
      wd[i] = (i == 1) ? (r & 8'hFD) : r;
      apb(IDX_T[i], 1'b1, wd[i]);
      rd(IDX_T[i], {25'h0, (wd[i] & MSK_T[i]) | (RST_T[i] & ~MSK_T[i])});
    end
    cmp_val("primaryBase", {17'h0, wd[2][3:0], wd[3][7:2], 2'b00}, 33'(primaryBase));
    cmp_val("secondaryBase", {17'h0, wd[4][3:0], wd[5][7:2], 2'b00}, 33'(secondaryBase));
    cmp_val("ecpEnable", 33'(wd[9][1]), 33'(ecpEnable));
    cmp_val("secondaryValid", 33'(wd[9][1]), 33'(secondaryValid));
    cmp_val("irqShared", 33'(wd[9][2]), 33'(irqShared));
    cmp_val("eppEnable", 33'(wd[9][0] & ~wd[3][2]), 33'(eppEnable));
    for (int v = 0; v < 16; v++) begin
      apb(IDX_IRQ_LVL, 1'b1, 8'(v));
      ok = (v == 0) || (v >= 3 && v <= 11);
      cmp_val("irqLevel", {ok, 28'h0, ok ? 4'(v) : 4'h0}, {irqLevelValid, 28'h0, irqLevel});
    end
    for (int v = 0; v < 8; v++) begin
      apb(IDX_DMA, 1'b1, 8'(v));
      ok = (v < 4);
      cmp_val("dmaChannel", {ok, 29'h0, ok ? 3'(v) : 3'h4}, {dmaValid, 29'h0, dmaChannel});
    end
    apb(IDX_SPECIAL, 1'b1, 8'h01);
    apb(IDX_PBASE_LO, 1'b1, 8'h7C);
    cmp_val("eppEnable", 33'h0, 33'(eppEnable));
    apb(IDX_PBASE_LO, 1'b1, 8'h78);
    cmp_val("eppEnable", 33'h1, 33'(eppEnable));
    // Range check: port off first, then the check, then host reads
    apb(IDX_SPECIAL, 1'b1, 8'h00);
    apb(IDX_ACT, 1'b1, 8'h00);
    apb(IDX_PBASE_HI, 1'b1, 8'h03);
    apb(IDX_RCHK, 1'b1, 8'h03);
    cmp_val("checkActive", 33'h1, 33'(checkActive));
    // Status: check on, last level Fh and last DMA 7h both invalid
    rd(IDX_STATUS, {25'h0, 8'h1C});
    probe(16'h0378, 1'b1, PAT_SET);
    probe(16'h037F, 1'b1, PAT_SET);
    probe(16'h0380, 1'b0, 8'h00);
    probe(16'h0377, 1'b0, 8'h00);
    apb(IDX_RCHK, 1'b1, 8'h02);
    probe(16'h037A, 1'b1, PAT_CLR);
    apb(IDX_SBASE_HI, 1'b1, 8'h07);
    apb(IDX_SBASE_LO, 1'b1, 8'h78);
    probe(16'h0778, 1'b0, 8'h00);
    apb(IDX_SPECIAL, 1'b1, 8'h02);
    probe(16'h077B, 1'b1, PAT_CLR);
    apb(IDX_CFG_MODE, 1'b1, 8'h01);
    probe(16'h0378, 1'b0, 8'h00);
    apb(IDX_CFG_MODE, 1'b1, 8'h00);
    apb(IDX_RCHK, 1'b1, 8'h00);
    apb(IDX_ACT, 1'b1, 8'h01);
    cmp_val("portEnable", 33'h1, 33'(portEnable));
    probe(16'h0378, 1'b0, 8'h00);
    // Mid-run reset puts every output back and hides the bank again
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    cmp_val("primaryBase", 33'({RST_PBASE_HI[3:0], RST_PBASE_LO}), 33'(primaryBase));
    cmp_val("secondaryBase", 33'({RST_SBASE_HI[3:0], RST_SBASE_LO}), 33'(secondaryBase));
    cmp_val("irqLevel", 33'({1'b1, RST_IRQ_LVL[3:0]}), 33'({irqLevelValid, irqLevel}));
    cmp_val("dmaChannel", 33'({1'b1, RST_DMA[2:0]}), 33'({dmaValid, dmaChannel}));
    cmp_val("modeOutputs", 33'({RST_SPECIAL[2:0], RST_ACT[0]}),
            33'({irqShared, ecpEnable, eppEnable, portEnable}));
    cmp_val("checkActive", 33'h0, 33'(checkActive));
    rd(IDX_PBASE_HI, 33'h0);
    repeat (5) @(posedge clk);
    if (rdq.size() != 0 || ioq.size() != 0)
      cmp_val("pending notes", 33'h0, 33'(rdq.size() + ioq.size()));
    complete_run();
  end
endmodule : tb_top
